// file: shared/dcp_consts.svh
// Constants for the drive configuration parameter bank.
// Assumes inclusion by bare name from the package and the design module.
`ifndef DCP_CONSTS_SVH
`define DCP_CONSTS_SVH

// Parameter addresses (16-bit word address)
`define DCP_ADDR_STARTUP_ENABLE 16'h050c
`define DCP_ADDR_MOVE_INVERT    16'h0618
`define DCP_ADDR_COUNT_INVERT   16'h080e
`define DCP_ADDR_PANEL_LOCK     16'h3a02

// Power-on values; rst does not reload them
`define DCP_RST_STARTUP_ENABLE  16'h0000
`define DCP_RST_MOVE_INVERT     16'h0000
`define DCP_RST_COUNT_INVERT    16'h0000
`define DCP_RST_PANEL_LOCK      16'h0000

// Highest legal values
`define DCP_MAX_STARTUP_ENABLE  16'h0002
`define DCP_MAX_MOVE_INVERT     16'h0001
`define DCP_MAX_COUNT_INVERT    16'h0001
`define DCP_MAX_PANEL_LOCK      16'h0001

// Start-up enable modes
`define DCP_MODE_EDGE           2'h0
`define DCP_MODE_LEVEL          2'h1
`define DCP_MODE_AUTO           2'h2

// Read value of an unmapped address
`define DCP_RDATA_NONE          16'h0000

`endif

// file: shared/dcp_pkg.sv
// Types for the drive configuration parameter bank.
// Assumes dcp_consts.svh is on the include path.
package dcp_pkg;
  `include "dcp_consts.svh"

  typedef logic [15:0] dcp_word_t;
  typedef logic [1:0]  dcp_mode_t;

  typedef enum logic [2:0] {
    DCP_ST_WAIT = 3'b001,
    DCP_ST_ON   = 3'b010,
    DCP_ST_OFF  = 3'b100
  } dcp_state_t;
endpackage

// file: rtl/dcp_param_bank.sv
// Drive configuration parameter bank with power-stage start-up control.
// Assumes a synchronous parameter access port from fieldbus or panel logic
// on clk; enable and pulse-train pins are asynchronous.
`timescale 1ns/1ps
`include "dcp_consts.svh"

// Operation
// - Panel lock: 0 unlocked, 1 locked
// - Locked panel cannot start change, jog, tune, reset
// - Panel lock takes effect immediately
// - Count inversion applies to pulse-train counting
// - Count inversion 0 normal, 1 reversed
// - Movement inversion 0 normal, 1 reversed
// - Movement inversion changes only while stage disabled
// - Movement inversion applies after next power-on
// - Mode 0: enable on enable rising edge
// - Mode 1: enable while enable input active; the stage stays on after the input drops, until stage_disable_req
// - Mode 2: enable automatically after start-up
// - Start-up mode change used at next start-up after power-on, not on restart from off
module dcp_param_bank (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Parameter access port
  input  wire logic           prm_req,
  input  wire logic           prm_we,
  input  wire logic           prm_from_panel,
  input  wire logic [15:0]    prm_addr,
  input  wire dcp_pkg::dcp_word_t prm_wdata,
  output logic                prm_ack,
  output logic                prm_err,
  output dcp_pkg::dcp_word_t  prm_rdata,
  // Panel function requests
  input  wire logic           panel_jog_req,
  input  wire logic           panel_tune_req,
  input  wire logic           panel_fault_reset_req,
  output logic                jog_start,
  output logic                tune_start,
  output logic                fault_reset_start,
  output logic                panel_locked,
  // Pulse-train input pins
  input  wire logic           pulse_train_input_pulse,
  input  wire logic           pulse_train_input_dir,
  output logic                count_up,
  output logic                count_down,
  // Movement direction
  input  wire logic           move_dir_cmd,
  output logic                motor_dir,
  // Power stage
  input  wire logic           enable_pin,
  input  wire logic           stage_disable_req,
  output logic                power_stage_en
);
  import dcp_pkg::*;

  // Settings survive rst like a persistent store; the declared value is power-on
  dcp_word_t  panel_lock_q = `DCP_RST_PANEL_LOCK;
  dcp_word_t  count_inv_q  = `DCP_RST_COUNT_INVERT;
  dcp_word_t  move_inv_q   = `DCP_RST_MOVE_INVERT;
  dcp_word_t  startup_q    = `DCP_RST_STARTUP_ENABLE;
  dcp_word_t  panel_lock_d;
  dcp_word_t  count_inv_d;
  dcp_word_t  move_inv_d;
  dcp_word_t  startup_d;
  logic       move_inv_act_q, move_inv_act_d;
  dcp_mode_t  mode_act_q, mode_act_d;
  logic       booted_q, booted_d;
  dcp_state_t state_q, state_d;
  logic       ack_q, ack_d;
  logic       err_q, err_d;
  dcp_word_t  rdata_q, rdata_d;
  logic       jog_q, jog_d;
  logic       tune_q, tune_d;
  logic       frst_q, frst_d;
  logic       up_q, up_d;
  logic       dn_q, dn_d;
  logic       mdir_q, mdir_d;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       pulse_prev_q;
  logic       en_prev_q;

  // Pin synchronisers: enable, pulse, direction
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q      <= 3'h0;
      sync2_q      <= 3'h0;
      pulse_prev_q <= 1'b0;
      en_prev_q    <= 1'b0;
    end else begin
      sync1_q      <= {pulse_train_input_dir, pulse_train_input_pulse, enable_pin};
      sync2_q      <= sync1_q;
      pulse_prev_q <= sync2_q[1];
      en_prev_q    <= sync2_q[0];
    end
  end

  function automatic logic in_range(input dcp_word_t v, input dcp_word_t max);
    in_range = (v <= max);
  endfunction

  logic en_lvl;
  logic en_rise;
  logic pulse_rise;
  logic wr;
  logic refuse;

  always_comb begin
    en_lvl         = sync2_q[0];
    en_rise        = sync2_q[0] & ~en_prev_q;
    pulse_rise     = sync2_q[1] & ~pulse_prev_q;
    panel_lock_d   = panel_lock_q;
    count_inv_d    = count_inv_q;
    move_inv_d     = move_inv_q;
    startup_d      = startup_q;
    move_inv_act_d = move_inv_act_q;
    mode_act_d     = mode_act_q;
    booted_d       = 1'b1;
    state_d        = state_q;
    ack_d          = prm_req;
    err_d          = 1'b0;
    rdata_d        = `DCP_RDATA_NONE;
    // Lock is read from the live register, no shadow copy
    refuse         = prm_from_panel & panel_lock_q[0];
    wr             = prm_req & prm_we & ~refuse;
    if (prm_req & prm_we & refuse) begin
      err_d = 1'b1;
    end
    if (prm_req & ~prm_we) begin
      case (prm_addr)
        `DCP_ADDR_PANEL_LOCK:     rdata_d = panel_lock_q;
        `DCP_ADDR_COUNT_INVERT:   rdata_d = count_inv_q;
        `DCP_ADDR_MOVE_INVERT:    rdata_d = move_inv_q;
        `DCP_ADDR_STARTUP_ENABLE: rdata_d = startup_q;
        default:                  err_d   = 1'b1;
      endcase
    end
    if (wr) begin
      case (prm_addr)
        `DCP_ADDR_PANEL_LOCK: begin
          if (in_range(prm_wdata, `DCP_MAX_PANEL_LOCK)) panel_lock_d = prm_wdata;
          else err_d = 1'b1;
        end
        `DCP_ADDR_COUNT_INVERT: begin
          if (in_range(prm_wdata, `DCP_MAX_COUNT_INVERT)) count_inv_d = prm_wdata;
          else err_d = 1'b1;
        end
        `DCP_ADDR_MOVE_INVERT: begin
          if (in_range(prm_wdata, `DCP_MAX_MOVE_INVERT) && !power_stage_en) begin
            move_inv_d = prm_wdata;
          end else begin
            err_d = 1'b1;
          end
        end
        `DCP_ADDR_STARTUP_ENABLE: begin
          if (in_range(prm_wdata, `DCP_MAX_STARTUP_ENABLE)) startup_d = prm_wdata;
          else err_d = 1'b1;
        end
        default: err_d = 1'b1;
      endcase
    end
    // Movement inversion copied only at the first cycle after power-on
    if (!booted_q) begin
      move_inv_act_d = move_inv_q[0];
    end
    // Panel functions blocked while locked
    jog_d  = panel_jog_req & ~panel_lock_q[0];
    tune_d = panel_tune_req & ~panel_lock_q[0];
    frst_d = panel_fault_reset_req & ~panel_lock_q[0];
    // Pulse-train counting with optional inversion
    up_d   = pulse_rise & (sync2_q[2] ^ count_inv_q[0]);
    dn_d   = pulse_rise & ~(sync2_q[2] ^ count_inv_q[0]);
    mdir_d = move_dir_cmd ^ move_inv_act_q;
    // Power stage enable sequence
    case (state_q)
      DCP_ST_WAIT: begin
        if (booted_q && !stage_disable_req) begin
          case (mode_act_q)
            `DCP_MODE_EDGE:  if (en_rise) state_d = DCP_ST_ON;
            `DCP_MODE_LEVEL: if (en_lvl) state_d = DCP_ST_ON;
            `DCP_MODE_AUTO:  state_d = DCP_ST_ON;
            default:         state_d = DCP_ST_WAIT;
          endcase
        end
      end
      DCP_ST_ON: begin
        if (stage_disable_req) state_d = DCP_ST_OFF;
      end
      DCP_ST_OFF: begin
        if (en_rise && !stage_disable_req) state_d = DCP_ST_ON;
      end
      default: state_d = DCP_ST_WAIT;
    endcase
    // Mode follows the register while the stage is off, frozen once it is on
    if (state_q != DCP_ST_ON) begin
      mode_act_d = startup_q[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      move_inv_act_q <= 1'b0;
      mode_act_q     <= `DCP_MODE_EDGE;
      booted_q       <= 1'b0;
      state_q        <= DCP_ST_WAIT;
      ack_q          <= 1'b0;
      err_q          <= 1'b0;
      rdata_q        <= `DCP_RDATA_NONE;
      jog_q          <= 1'b0;
      tune_q         <= 1'b0;
      frst_q         <= 1'b0;
      up_q           <= 1'b0;
      dn_q           <= 1'b0;
      mdir_q         <= 1'b0;
    end else begin
      move_inv_act_q <= move_inv_act_d;
      mode_act_q     <= mode_act_d;
      booted_q       <= booted_d;
      state_q        <= state_d;
      ack_q          <= ack_d;
      err_q          <= err_d;
      rdata_q        <= rdata_d;
      jog_q          <= jog_d;
      tune_q         <= tune_d;
      frst_q         <= frst_d;
      up_q           <= up_d;
      dn_q           <= dn_d;
      mdir_q         <= mdir_d;
    end
  end

  // Stored settings: rst does not clear them, so next power-on sees them
  always_ff @(posedge clk) begin
    if (!rst) begin
      panel_lock_q <= panel_lock_d;
      count_inv_q  <= count_inv_d;
      move_inv_q   <= move_inv_d;
      startup_q    <= startup_d;
    end
  end

  assign prm_ack           = ack_q;
  assign prm_err           = err_q;
  assign prm_rdata         = rdata_q;
  assign jog_start         = jog_q;
  assign tune_start        = tune_q;
  assign fault_reset_start = frst_q;
  assign panel_locked      = panel_lock_q[0];
  assign count_up          = up_q;
  assign count_down        = dn_q;
  assign motor_dir         = mdir_q;
  assign power_stage_en    = (state_q == DCP_ST_ON);
endmodule

// file: sim/dcp_param_bank_assertions.sv
// Port checker for the parameter bank.
// Assumes a bind to dcp_param_bank and one clock domain.
`timescale 1ns/1ps
module dcp_param_bank_assertions (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Access port
  input wire logic               prm_req,
  input wire logic               prm_we,
  input wire logic               prm_from_panel,
  input wire logic [15:0]        prm_addr,
  input wire dcp_pkg::dcp_word_t prm_wdata,
  input wire logic               prm_ack,
  input wire logic               prm_err,
  // Panel, counter and stage
  input wire logic               panel_jog_req,
  input wire logic               jog_start,
  input wire logic               panel_locked,
  input wire logic               count_up,
  input wire logic               count_down,
  input wire logic               power_stage_en
);
  wire logic wr = prm_req && prm_we;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_next: assert property (prm_req |=> prm_ack) else $error("no ack");
  a_ack_cause: assert property (prm_ack |-> $past(prm_req)) else $error("stray ack");
  a_lock_now: assert property (wr && !prm_from_panel && prm_addr == 16'h3a02 &&
    prm_wdata <= 16'h0001 |=> panel_locked == $past(prm_wdata[0])) else $error("lock late");
  a_panel_refused: assert property (wr && prm_from_panel && panel_locked |=> prm_err)
    else $error("panel write taken");
  a_range_refused: assert property (wr && prm_addr == 16'h3a02 && prm_wdata > 16'h0001
    |=> prm_err && $stable(panel_locked)) else $error("range taken");
  a_jog_gate: assert property (jog_start |-> $past(panel_jog_req) &&
    !$past(panel_locked)) else $error("jog not gated");
  a_jog_pass: assert property (panel_jog_req && !panel_locked |=> jog_start)
    else $error("jog lost");
  a_move_busy: assert property (wr && prm_addr == 16'h0618 && power_stage_en |=> prm_err)
    else $error("invert taken");
  a_count_one: assert property (count_up |-> !count_down) else $error("both counts");
  c_locked: cover property (wr && prm_from_panel && panel_locked);
  c_jog: cover property (jog_start);
  c_stage: cover property (power_stage_en);
endmodule

bind dcp_param_bank dcp_param_bank_assertions chk_u (
  .clk            (clk),
  .rst            (rst),
  .prm_req        (prm_req),
  .prm_we         (prm_we),
  .prm_from_panel (prm_from_panel),
  .prm_addr       (prm_addr),
  .prm_wdata      (prm_wdata),
  .prm_ack        (prm_ack),
  .prm_err        (prm_err),
  .panel_jog_req  (panel_jog_req),
  .jog_start      (jog_start),
  .panel_locked   (panel_locked),
  .count_up       (count_up),
  .count_down     (count_down),
  .power_stage_en (power_stage_en)
);

// file: sim/dcp_fieldbus_master.sv
// Fieldbus master model for the parameter access port.
// Assumes the bench clock; drives at the falling edge.
`timescale 1ns/1ps
module dcp_fieldbus_master (
  // Clock
  input  wire logic         clk,
  // Access port
  output logic              prm_req,
  output logic              prm_we,
  output logic              prm_from_panel,
  output logic [15:0]       prm_addr,
  output logic [15:0]       prm_wdata,
  input  wire logic         prm_ack,
  input  wire logic         prm_err,
  input  wire logic [15:0]  prm_rdata
);
  initial begin
    {prm_req, prm_we, prm_from_panel, prm_addr, prm_wdata} = '0;
  end
  // One-cycle request, answer taken the cycle after
  task automatic access(input logic we, pnl, input logic [15:0] a, d,
                        output logic [1:0] ae, output logic [15:0] rd);
    @(negedge clk);
    {prm_req, prm_we, prm_from_panel, prm_addr, prm_wdata} = {1'b1, we, pnl, a, d};
    @(negedge clk);
    ae = {prm_ack, prm_err};
    rd = prm_rdata;
    // Released lines no longer show the last access
    {prm_req, prm_addr, prm_wdata} = {1'b0, ~a, ~d};
  endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the parameter bank.
// Assumes the fieldbus model and the bound checker.
`timescale 1ns/1ps
module tb;
  import dcp_pkg::*;
  logic clk, rst, prm_req, prm_we, prm_from_panel, prm_ack, prm_err, panel_jog_req;
  logic panel_tune_req, panel_fault_reset_req, jog_start, tune_start, fault_reset_start;
  logic panel_locked, pulse_train_input_pulse, pulse_train_input_dir, count_up, count_down;
  logic move_dir_cmd, motor_dir, enable_pin, stage_disable_req, power_stage_en;
  logic [15:0] prm_addr, prm_wdata, prm_rdata;
  int mismatches, checked;
  dcp_param_bank dut_u (
    .clk                     (clk),
    .rst                     (rst),
    .prm_req                 (prm_req),
    .prm_we                  (prm_we),
    .prm_from_panel          (prm_from_panel),
    .prm_addr                (prm_addr),
    .prm_wdata               (prm_wdata),
    .prm_ack                 (prm_ack),
    .prm_err                 (prm_err),
    .prm_rdata               (prm_rdata),
    .panel_jog_req           (panel_jog_req),
    .panel_tune_req          (panel_tune_req),
    .panel_fault_reset_req   (panel_fault_reset_req),
    .jog_start               (jog_start),
    .tune_start              (tune_start),
    .fault_reset_start       (fault_reset_start),
    .panel_locked            (panel_locked),
    .pulse_train_input_pulse (pulse_train_input_pulse),
    .pulse_train_input_dir   (pulse_train_input_dir),
    .count_up                (count_up),
    .count_down              (count_down),
    .move_dir_cmd            (move_dir_cmd),
    .motor_dir               (motor_dir),
    .enable_pin              (enable_pin),
    .stage_disable_req       (stage_disable_req),
    .power_stage_en          (power_stage_en)
  );
  dcp_fieldbus_master fb_u (
    .clk            (clk),
    .prm_req        (prm_req),
    .prm_we         (prm_we),
    .prm_from_panel (prm_from_panel),
    .prm_addr       (prm_addr),
    .prm_wdata      (prm_wdata),
    .prm_ack        (prm_ack),
    .prm_err        (prm_err),
    .prm_rdata      (prm_rdata)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic we, p, input logic [15:0] a, d, input logic [1:0] ae,
                     input logic [15:0] rx);
    logic [1:0] g;
    logic [15:0] r;
    fb_u.access(we, p, a, d, g, r);
    chk(16'(g), 16'(ae));
    chk(r, rx);
  endtask
  task automatic pfn(input logic [2:0] e);
    {panel_jog_req, panel_tune_req, panel_fault_reset_req} = 3'h7;
    @(negedge clk);
    {panel_jog_req, panel_tune_req, panel_fault_reset_req} = 3'h0;
    chk(16'({jog_start, tune_start, fault_reset_start}), 16'(e));
  endtask
  task automatic pulse(input logic [1:0] e);
    pulse_train_input_pulse = 1'b1;
    for (int i = 0; i < 10 && !(count_up | count_down); i++) @(negedge clk);
    chk(16'({count_up, count_down}), 16'(e));
    pulse_train_input_pulse = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_regs();
    acc(0, 0, 16'h050c, 0, 2'h2, 0);
    acc(0, 0, 16'h0618, 0, 2'h2, 0);
    acc(0, 0, 16'h080e, 0, 2'h2, 0);
    acc(0, 0, 16'h3a02, 0, 2'h2, 0);
    acc(0, 0, 16'h0001, 0, 2'h3, 0);
  endtask
  task automatic t_stage();
    repeat (6) @(negedge clk);
    chk(16'(power_stage_en), 16'h0);
    acc(1, 0, 16'h0618, 1, 2'h2, 0);
    move_dir_cmd = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(motor_dir), 16'h1);
    enable_pin = 1'b1;
    for (int i = 0; i < 10 && !power_stage_en; i++) @(negedge clk);
    chk(16'(power_stage_en), 16'h1);
    acc(1, 0, 16'h0618, 0, 2'h3, 0);
    stage_disable_req = 1'b1;
    repeat (2) @(negedge clk);
    stage_disable_req = 1'b0;
    chk(16'(power_stage_en), 16'h0);
  endtask
  task automatic t_lock();
    acc(1, 0, 16'h3a02, 1, 2'h2, 0);
    chk(16'(panel_locked), 16'h1);
    acc(1, 1, 16'h080e, 1, 2'h3, 0);
    acc(0, 1, 16'h080e, 0, 2'h2, 0);
    pfn(3'h0);
    acc(1, 0, 16'h3a02, 0, 2'h2, 0);
    pfn(3'h7);
  endtask
  task automatic t_range();
    acc(1, 0, 16'h050c, 3, 2'h3, 0);
    acc(1, 0, 16'h050c, 2, 2'h2, 0);
    acc(0, 0, 16'h050c, 0, 2'h2, 2);
    acc(1, 1, 16'h3a02, 2, 2'h3, 0);
  endtask
  task automatic t_count();
    pulse(2'h2);
    acc(1, 0, 16'h080e, 1, 2'h2, 0);
    pulse(2'h1);
    pulse_train_input_dir = 1'b0;
    pulse(2'h2);
  endtask
  task automatic t_boot();
    rst = 1'b1;
    enable_pin = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk(16'(power_stage_en), 16'h0);
    for (int i = 0; i < 10 && !power_stage_en; i++) @(negedge clk);
    chk(16'(power_stage_en), 16'h1);
    // Bench takes motor_dir 1 as the move toward the positive limit switch
    chk(16'(motor_dir), 16'h0);
    acc(1, 0, 16'h050c, 1, 2'h2, 0);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(power_stage_en), 16'h0);
    enable_pin = 1'b1;
    for (int i = 0; i < 10 && !power_stage_en; i++) @(negedge clk);
    chk(16'(power_stage_en), 16'h1);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    {panel_jog_req, panel_tune_req, panel_fault_reset_req, move_dir_cmd} = '0;
    {pulse_train_input_pulse, enable_pin, stage_disable_req} = '0;
    pulse_train_input_dir = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_stage();
    t_lock();
    t_range();
    t_count();
    t_boot();
    complete_run();
  end
endmodule
